// ### common/hisc_pkg.sv
// Constants for the halt and light idle standby controller.
// Assumes one system clock domain; register bits arrive on a plain port.
package hisc_pkg;
    // Standby-select field value that chooses light idle
    localparam logic [1:0] SEL_LIGHT_IDLE = 2'h0;
    // Bit positions in power_save_control_reg
    localparam int PSC_REQ_BIT      = 1;
    localparam int PSC_WDT_MASK_BIT = 2;
    localparam int PSC_NMI_MASK_BIT = 3;
    localparam int PSC_INT_MASK_BIT = 4;
    // Bit positions in power_save_mode_reg
    localparam int POWER_SAVE_MODE_REG_SEL_LO_BIT  = 0;
    localparam int POWER_SAVE_MODE_REG_SEL_HI_BIT  = 1;
    // Register indices on the plain port
    localparam logic [1:0] ADDR_PSC    = 2'h0;
    localparam logic [1:0] ADDR_POWER_SAVE_MODE_REG   = 2'h1;
    localparam logic [1:0] ADDR_STATUS = 2'h2;
    localparam logic [7:0] REG_RESET   = 8'h00;
    // Peripheral gate indices
    localparam int GATE_SUBCLK = 0;
    localparam int GATE_EXTCLK = 1;
    // Count clock selects of the timers
    localparam logic [1:0] TCLK_MAIN = 2'h0;
    localparam logic [1:0] TCLK_SUB  = 2'h1;
    localparam logic [1:0] TCLK_BRG  = 2'h2;

    typedef enum logic [2:0] {
        HISC_RUN  = 3'h1,
        HISC_HALT = 3'h2,
        HISC_IDLE = 3'h4
    } hisc_state_t;
endpackage

// ### rtl/hisc_ctrl.sv
// Halt and light idle standby controller: clock gates, wake decision, resume kind.
// Assumes interrupt requests come from same-clock logic; reset pins are synchronised here.
`timescale 1ns/1ps
module hisc_ctrl #(
    parameter int NUM_PRIO = 8
) (
    input  wire logic                       clk_sys,
    input  wire logic                       reset,
    input  wire logic [1:0]                 regAddr,
    input  wire logic [7:0]                 regWdata,
    input  wire logic                       regWrite,
    input  wire logic                       regRead,
    output logic [7:0]                      regRdata,
    input  wire logic                       haltExec,
    input  wire logic                       nmiPin,
    input  wire logic                       watchdogInterrupt,
    input  wire logic                       maskableReq,
    input  wire logic [$clog2(NUM_PRIO)-1:0] reqPrio,
    input  wire logic                       inService,
    input  wire logic [$clog2(NUM_PRIO)-1:0] servicePrio,
    input  wire logic                       interruptsEnabled,
    input  wire logic                       resetPin,
    input  wire logic                       watchdogReset,
    input  wire logic                       lowVoltageDetectReset,
    input  wire logic                       clockMonitorReset,
    input  wire logic                       subclockUsed,
    input  wire logic [1:0]                 intervalTimerClk,
    input  wire logic [1:0]                 watchdogClk,
    input  wire logic [1:0]                 watchTimerClk,
    output logic                            cpuClkEn,
    output logic                            periphClkEn,
    output logic [1:0]                      altPeriphClkEn,
    output logic                            intervalTimerEn,
    output logic                            watchdogTimerEn,
    output logic                            watchTimerEn,
    output logic                            portHold,
    output logic                            cpuStateHold,
    output logic                            coreReset,
    output logic                            wakeAck,
    output logic                            wakeBranch,
    output logic                            wakePulse
);
    import hisc_pkg::*;

    // Reset pins come from outside the clock domain
    logic [3:0] rstSync1;
    logic [3:0] rstSync2;
    always_ff @(posedge clk_sys) begin
        rstSync1 <= {resetPin, watchdogReset, lowVoltageDetectReset, clockMonitorReset};
        rstSync2 <= rstSync1;
    end
    logic anyReset;
    assign anyReset = |rstSync2;

    function automatic logic timerRuns(input logic [1:0] sel, input logic sub);
        timerRuns = sub || (sel != TCLK_SUB);
    endfunction

    function automatic logic isRun(input hisc_state_t s);
        isRun = (s == HISC_RUN);
    endfunction

    hisc_state_t state;
    hisc_state_t next_state;
    logic [7:0]  powerSaveControlReg;
    logic [7:0]  next_powerSaveControlReg;
    logic [7:0]  powerSaveModeReg;
    logic [7:0]  next_powerSaveModeReg;
    logic        inSvcAtEntry;
    logic        next_inSvcAtEntry;
    logic [$clog2(NUM_PRIO)-1:0] svcPrioAtEntry;
    logic [$clog2(NUM_PRIO)-1:0] next_svcPrioAtEntry;
    logic [7:0]  next_regRdata;
    logic        next_cpuClkEn;
    logic        next_periphClkEn;
    logic [1:0]  next_altPeriphClkEn;
    logic        next_intervalTimerEn;
    logic        next_watchdogTimerEn;
    logic        next_watchTimerEn;
    logic        next_wakeAck;
    logic        next_wakeBranch;
    logic        next_wakePulse;
    logic        next_portHold;
    logic        next_cpuStateHold;
    logic        next_coreReset;

    logic nmiWakeHalt;
    logic nmiWakeIdle;
    logic wakeHalt;
    logic wakeIdle;
    logic higherPrio;
    logic wake;

    // Wake sources; masks only count in light idle
    always_comb begin
        nmiWakeHalt = nmiPin || watchdogInterrupt;
        nmiWakeIdle = (nmiPin && !powerSaveControlReg[PSC_NMI_MASK_BIT])
                   || (watchdogInterrupt && !powerSaveControlReg[PSC_WDT_MASK_BIT]);
        wakeHalt = nmiWakeHalt || maskableReq;
        wakeIdle = nmiWakeIdle
                || (maskableReq && !powerSaveControlReg[PSC_INT_MASK_BIT]);
        // Priority judged against the context captured at entry, not the live one
        higherPrio = !inSvcAtEntry || (reqPrio < svcPrioAtEntry);
    end

    always_comb begin
        next_state               = state;
        next_powerSaveControlReg = powerSaveControlReg;
        next_powerSaveModeReg    = powerSaveModeReg;
        next_inSvcAtEntry        = inSvcAtEntry;
        next_svcPrioAtEntry      = svcPrioAtEntry;
        next_wakeAck             = 1'b0;
        next_wakeBranch          = 1'b0;
        next_wakePulse           = 1'b0;
        wake = 1'b0;

        if (regWrite && regAddr == ADDR_PSC) begin
            next_powerSaveControlReg = regWdata;
        end
        if (regWrite && regAddr == ADDR_POWER_SAVE_MODE_REG) begin
            next_powerSaveModeReg = regWdata;
        end
        case (state)
            HISC_RUN: begin
                // Capture service context so the wake can be judged by priority
                next_inSvcAtEntry   = inService;
                next_svcPrioAtEntry = servicePrio;
                if (haltExec) begin
                    next_state = HISC_HALT;
                end else if (powerSaveControlReg[PSC_REQ_BIT]
                    && {powerSaveModeReg[POWER_SAVE_MODE_REG_SEL_HI_BIT], powerSaveModeReg[POWER_SAVE_MODE_REG_SEL_LO_BIT]}
                       == SEL_LIGHT_IDLE) begin
                    next_state = HISC_IDLE;
                end
            end
            HISC_HALT: wake = wakeHalt;
            HISC_IDLE: wake = wakeIdle;
            default:   next_state = HISC_RUN;
        endcase

        if (wake) begin
            // Straight back to run: the oscillator never stopped
            next_state = HISC_RUN;
            next_powerSaveControlReg[PSC_REQ_BIT] = 1'b0;
            next_wakePulse = 1'b1;
            if (nmiWakeHalt && state == HISC_HALT || nmiWakeIdle) begin
                next_wakeAck    = 1'b1;
                next_wakeBranch = 1'b1;
            end else begin
                // Lower priority wakes without acknowledge and stays pending
                next_wakeAck    = higherPrio && interruptsEnabled;
                next_wakeBranch = higherPrio && interruptsEnabled;
            end
        end

        if (anyReset) begin
            next_state               = HISC_RUN;
            next_powerSaveControlReg = REG_RESET;
            next_powerSaveModeReg    = REG_RESET;
            next_wakeAck             = 1'b0;
            next_wakeBranch          = 1'b0;
            next_wakePulse           = 1'b0;
        end

    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state               <= HISC_RUN;
            powerSaveControlReg <= REG_RESET;
            powerSaveModeReg    <= REG_RESET;
            inSvcAtEntry        <= 1'b0;
            svcPrioAtEntry      <= '0;
            wakeAck             <= 1'b0;
            wakeBranch          <= 1'b0;
            wakePulse           <= 1'b0;
        end else begin
            state               <= next_state;
            powerSaveControlReg <= next_powerSaveControlReg;
            powerSaveModeReg    <= next_powerSaveModeReg;
            inSvcAtEntry        <= next_inSvcAtEntry;
            svcPrioAtEntry      <= next_svcPrioAtEntry;
            wakeAck             <= next_wakeAck;
            wakeBranch          <= next_wakeBranch;
            wakePulse           <= next_wakePulse;
        end
    end

    // Read data stand one cycle after the strobe and are zero otherwise
    always_comb begin
        next_regRdata = REG_RESET;
        if (regRead) begin
            case (regAddr)
                ADDR_PSC:    next_regRdata = powerSaveControlReg;
                ADDR_POWER_SAVE_MODE_REG:   next_regRdata = powerSaveModeReg;
                ADDR_STATUS: next_regRdata = {5'h00, state};
                default:     next_regRdata = REG_RESET;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            regRdata <= REG_RESET;
        end else begin
            regRdata <= next_regRdata;
        end
    end

    // Gates follow next state so clocks return on the wake edge
    always_comb begin
        next_cpuClkEn        = isRun(next_state);
        next_periphClkEn     = (next_state != HISC_IDLE);
        // Subclock and external-clock peripherals never lean on the core clock
        next_altPeriphClkEn  = 2'h3;
        next_intervalTimerEn = (next_state == HISC_IDLE) ? 1'b0
                             : isRun(next_state)
                             || timerRuns(intervalTimerClk, subclockUsed);
        // In light idle the watchdog still has a clock to count only when subclock-fed
        next_watchdogTimerEn = (next_state == HISC_IDLE)
                             ? (subclockUsed && (watchdogClk == TCLK_SUB))
                             : isRun(next_state)
                             || timerRuns(watchdogClk, subclockUsed);
        next_watchTimerEn    = isRun(next_state) || subclockUsed
                             || (watchTimerClk == TCLK_BRG);
        next_portHold        = !isRun(next_state);
        next_cpuStateHold    = !isRun(next_state);
        // Core reset lags the synchroniser by one edge so it is glitch-free
        next_coreReset       = anyReset;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cpuClkEn        <= 1'b1;
            periphClkEn     <= 1'b1;
            altPeriphClkEn  <= 2'h3;
            intervalTimerEn <= 1'b1;
            watchdogTimerEn <= 1'b1;
            watchTimerEn    <= 1'b1;
            portHold        <= 1'b0;
            cpuStateHold    <= 1'b0;
            coreReset       <= 1'b1;
        end else begin
            cpuClkEn        <= next_cpuClkEn;
            periphClkEn     <= next_periphClkEn;
            altPeriphClkEn  <= next_altPeriphClkEn;
            intervalTimerEn <= next_intervalTimerEn;
            watchdogTimerEn <= next_watchdogTimerEn;
            watchTimerEn    <= next_watchTimerEn;
            portHold        <= next_portHold;
            cpuStateHold    <= next_cpuStateHold;
            coreReset       <= next_coreReset;
        end
    end
endmodule

// ### tb/hisc_ctrl_props.sv
// Port checker for the standby controller.
// Assumes one clock domain; bound into every hisc_ctrl instance.
`timescale 1ns/1ps
module hisc_ctrl_props
    import hisc_pkg::*;
#(
    parameter int NUM_PRIO = 8
) (
    input wire logic                        clk_sys,
    input wire logic                        reset,
    input wire logic                        haltExec,
    input wire logic                        nmiPin,
    input wire logic                        watchdogInterrupt,
    input wire logic                        maskableReq,
    input wire logic [$clog2(NUM_PRIO)-1:0] reqPrio,
    input wire logic                        inService,
    input wire logic [$clog2(NUM_PRIO)-1:0] servicePrio,
    input wire logic                        resetPin,
    input wire logic                        subclockUsed,
    input wire logic                        cpuClkEn,
    input wire logic                        periphClkEn,
    input wire logic                        intervalTimerEn,
    input wire logic                        watchdogTimerEn,
    input wire logic                        watchTimerEn,
    input wire logic                        portHold,
    input wire logic                        cpuStateHold,
    input wire logic                        coreReset,
    input wire logic                        wakeAck,
    input wire logic                        wakeBranch,
    input wire logic                        wakePulse
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic inHalt;
    logic quiet;
    assign inHalt = !cpuClkEn && periphClkEn;
    assign quiet  = !coreReset && !nmiPin && !watchdogInterrupt;
    sequence wakeDone;
        cpuClkEn && wakePulse;
    endsequence
    a_halt_gates_cpu: assert property (haltExec && cpuClkEn && quiet && !maskableReq
        |=> inHalt) else $error("halt did not gate only the cpu clock");
    a_hold_tracks_gate: assert property (portHold == !cpuClkEn && cpuStateHold == portHold)
        else $error("hold outputs disagree with cpu gate");
    a_nmi_halt_branch: assert property (inHalt && nmiPin && !coreReset
        |=> wakeDone ##0 (wakeAck && wakeBranch)) else $error("nmi wake without branch");
    a_low_prio_noack: assert property (inHalt && maskableReq && quiet && inService
        && reqPrio > servicePrio |=> wakeDone ##0 !wakeAck) else $error("low priority acked");
    a_wake_clock_first: assert property (wakePulse |-> cpuClkEn)
        else $error("wake pulse with cpu clock gated");
    a_ack_on_wake: assert property (wakeAck |-> wakePulse)
        else $error("ack outside a wake");
    a_wake_single_pulse: assert property (wakePulse |=> !wakePulse)
        else $error("wake pulse longer than one cycle");
    a_reset_wins_halt: assert property (resetPin[*5] |-> coreReset ##1 (cpuClkEn && !portHold))
        else $error("reset did not clear standby");
    a_timers_with_sub: assert property ((subclockUsed && inHalt)[*2]
        |-> intervalTimerEn && watchdogTimerEn && watchTimerEn) else $error("timer stopped");
endmodule
bind hisc_ctrl hisc_ctrl_props #(.NUM_PRIO(NUM_PRIO)) u_props (.*);

// ### tb/hisc_cpu_model.sv
// CPU side model: register bus master and halt instruction issue.
// Assumes the controller samples every request on the rising clk_sys edge.
`timescale 1ns/1ps
module hisc_cpu_model
    import hisc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic [7:0] regRdata,
    output logic [1:0]      regAddr = 2'h0,
    output logic [7:0]      regWdata = 8'h00,
    output logic            regWrite = 1'b0,
    output logic            regRead = 1'b0,
    output logic            haltExec = 1'b0
);
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        // No-op gap after a standby store, as real code must
        if (a == ADDR_PSC && d[PSC_REQ_BIT]) repeat (5) @(posedge clk_sys);
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic halt();
        @(posedge clk_sys);
        haltExec <= 1'b1;
        @(posedge clk_sys);
        haltExec <= 1'b0;
        #1;
    endtask
endmodule

// ### tb/hisc_ctrl_tb.sv
// Self-checking bench for the standby controller.
// Assumes the checker bind and the CPU model are compiled before it.
`timescale 1ns/1ps
module hisc_ctrl_tb;
    import hisc_pkg::*;
    typedef struct packed {
        logic [1:0] kind;
        logic       isr;
        logic [2:0] rp, sp;
        logic       ie, ack, br;
    } hisc_row_t;
    hisc_row_t  rows [6] = '{'{0,0,0,0,1,1,1}, '{0,0,0,0,0,0,0}, '{0,1,5,2,1,0,0},
                           '{0,1,2,5,1,1,1}, '{1,1,5,2,0,1,1}, '{2,0,0,0,1,1,1}};
    logic       clk_sys = 0, reset = 1, nmiPin = 0, watchdogInterrupt = 0, maskableReq = 0;
    logic       inService = 0, interruptsEnabled = 0, resetPin = 0, watchdogReset = 0;
    logic       lowVoltageDetectReset = 0, clockMonitorReset = 0, subclockUsed = 1;
    logic [2:0] reqPrio = 0, servicePrio = 0;
    logic [1:0] intervalTimerClk = 0, watchdogClk = 0, watchTimerClk = 0, regAddr, altPeriphClkEn;
    logic [7:0] regWdata, regRdata, rdv;
    logic       regWrite, regRead, haltExec, cpuClkEn, periphClkEn, intervalTimerEn, portHold;
    logic       watchdogTimerEn, watchTimerEn, cpuStateHold, coreReset, wakeAck, wakeBranch;
    logic       wakePulse;
    int         bad_count = 0, checks_done = 0, cycles = 0, wakes = 0, w0;
    hisc_ctrl #(.NUM_PRIO(8)) DUT (.*);
    hisc_cpu_model cpu (.*);
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        wakes  <= wakes + (wakePulse === 1'b1);
        if (cycles == 3000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic final_report();
        $display("mismatches %0d of %0d checks", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    initial begin
        tick(8);
        reset <= 0;
        tick(5);
        chk(coreReset, 0);
        cpu.wr(ADDR_PSC, 8'h1c);
        foreach (rows[i]) begin
            inService <= rows[i].isr;
            reqPrio <= rows[i].rp;
            servicePrio <= rows[i].sp;
            interruptsEnabled <= rows[i].ie;
            cpu.halt();
            chk({cpuClkEn, periphClkEn, portHold, cpuStateHold}, 8'h07);
            @(posedge clk_sys);
            maskableReq <= (rows[i].kind == 0);
            nmiPin <= (rows[i].kind == 1);
            watchdogInterrupt <= (rows[i].kind == 2);
            tick(1);
            chk({cpuClkEn, wakePulse}, 8'h03);
            chk({wakeAck, wakeBranch}, {6'h0, rows[i].ack, rows[i].br});
            @(posedge clk_sys);
            {maskableReq, nmiPin, watchdogInterrupt} <= 3'h0;
        end
        subclockUsed <= 0;
        intervalTimerClk <= TCLK_SUB;
        watchTimerClk <= TCLK_BRG;
        cpu.halt();
        tick(1);
        chk({intervalTimerEn, watchdogTimerEn, watchTimerEn}, 8'h03);
        intervalTimerClk <= TCLK_MAIN;
        watchdogClk <= TCLK_SUB;
        watchTimerClk <= TCLK_MAIN;
        tick(2);
        chk({intervalTimerEn, watchdogTimerEn, watchTimerEn}, 8'h04);
        resetPin <= 1;
        tick(6);
        chk({coreReset, cpuClkEn, portHold}, 8'h06);
        resetPin <= 0;
        subclockUsed <= 1;
        tick(6);
        cpu.wr(ADDR_POWER_SAVE_MODE_REG, 8'h00);
        cpu.wr(ADDR_PSC, 8'h12);
        #1 chk({cpuClkEn, periphClkEn, altPeriphClkEn}, 8'h03);
        cpu.rd(ADDR_STATUS, rdv);
        chk(rdv, 8'h04);
        maskableReq <= 1;
        tick(3);
        chk(cpuClkEn, 0);
        nmiPin <= 1;
        tick(1);
        chk({cpuClkEn, wakePulse}, 8'h03);
        nmiPin <= 0;
        cpu.rd(ADDR_PSC, rdv);
        chk(rdv, 8'h10);
        w0 = wakes;
        cpu.wr(ADDR_PSC, 8'h02);
        #1 chk(8'(wakes - w0), 8'h01);
        maskableReq <= 0;
        cpu.rd(2'h3, rdv);
        chk(rdv, 8'h00);
        final_report();
    end
endmodule
